// [shared/nbec_consts.vh]
// nbec_consts.vh: constants of the nand boot and ecc controller
// assumes: included by every design file of the block, by bare name
`ifndef NBEC_CONSTS_VH
`define NBEC_CONSTS_VH
// boot image size in bytes; page sizes as log2 of bytes
`define NBEC_BOOT_BYTES 13'h1000
`define NBEC_PG_LOG256  8
`define NBEC_PG_LOG512  9
// strap code for nand boot
`define NBEC_OM_NAND    2'h0
// flash command that opens a page read
`define NBEC_CMD_READ   8'h00
// last address byte index for 3 and 4 address cycles
`define NBEC_ADR_LAST3  2'h2
`define NBEC_ADR_LAST4  2'h3
// timing field reset values
`define NBEC_LATCH_SETUP_TIME_RST  3'h7
`define NBEC_TWRPH_RST  3'h0
// write-to-busy wait in clocks: 100 ns at 40 ns, rounded up
`define NBEC_TWB_CYC    4'h3
// strobe engine operations
`define NBEC_OP_CMD     2'h0
`define NBEC_OP_ADR     2'h1
`define NBEC_OP_WR      2'h2
`define NBEC_OP_RD      2'h3
// what answers at address zero
`define NBEC_MAP_ROM    2'h0
`define NBEC_MAP_SRAM   2'h1
`define NBEC_MAP_SDRAM  2'h2
// ecc: last byte index of a 512 byte block, line parity pairs
`define NBEC_ECC_LAST   9'h1FF
`define NBEC_ECC_LINES  9
`endif

// [design/nbec_sram.v]
// nbec_sram.v: 4 KB boot buffer, one port, registered read data
// assumes: caller muxes the boot copier and the processor onto the port
`timescale 1ns/10ps
`include "nbec_consts.vh"
module nbec_sram (
  input  wire        clk,
  input  wire        ce,
  input  wire        we,
  input  wire [11:0] addr,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata_q
);
  // not reset: filled by the boot copy
  reg [7:0] mem [0:4095];

  // shared port; a write reads the old byte
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
    end
  end
endmodule // nbec_sram

// [design/nbec_ecc.v]
// nbec_ecc.v: 24 bit hamming parity over 512 byte blocks
// assumes: valid pulses once per transferred byte, init restarts a block
`timescale 1ns/10ps
`include "nbec_consts.vh"
module nbec_ecc (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       init,
  input  wire       valid,
  input  wire [7:0] data,
  output wire [7:0] parity_byte_lo,
  output wire [7:0] parity_byte_mid,
  output wire [7:0] parity_byte_hi
);
  reg  [8:0]                 idx_q;  // byte position in the block
  reg  [`NBEC_ECC_LINES-1:0] lp_q;   // line parity P8..P2048
  reg  [`NBEC_ECC_LINES-1:0] lpn_q;  // line parity P8'..P2048'
  reg  [5:0]                 cp_q;   // P4 P4' P2 P2' P1 P1'
  wire                       bp;     // parity of the whole byte
  wire [5:0]                 cp_b;   // column parity of this byte
  genvar                     g;

  assign bp = ^data;
  assign cp_b = {^data[7:4], ^data[3:0],
                 ^{data[7:6], data[3:2]}, ^{data[5:4], data[1:0]},
                 ^{data[7], data[5], data[3], data[1]},
                 ^{data[6], data[4], data[2], data[0]}};

  // one pair per byte-address bit
  generate
    for (g = 0; g < `NBEC_ECC_LINES; g = g + 1) begin : g_line
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lp_q[g]  <= 1'b0;
          lpn_q[g] <= 1'b0;
        end else if (ce) begin
          if (init) begin
            lp_q[g]  <= 1'b0;
            lpn_q[g] <= 1'b0;
          end else if (valid) begin
            if (idx_q[g]) begin
              lp_q[g] <= lp_q[g] ^ bp; // R13
            end else begin
              lpn_q[g] <= lpn_q[g] ^ bp; // R13
            end
          end
        end
      end
    end
  endgenerate

  // column parity; counter wraps at 512
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_q  <= 6'h00;
      idx_q <= 9'h000;
    end else if (ce) begin
      if (init) begin
        cp_q  <= 6'h00;
        idx_q <= 9'h000;
      end else if (valid) begin
        cp_q  <= cp_q ^ cp_b; // R13
        idx_q <= idx_q + 9'h001; // R12
      end
    end
  end

  // packing, bit 7 first
  assign parity_byte_lo  = {lp_q[3], lpn_q[3], lp_q[2], lpn_q[2],
                            lp_q[1], lpn_q[1], lp_q[0], lpn_q[0]}; // R14
  assign parity_byte_mid = {lp_q[7], lpn_q[7], lp_q[6], lpn_q[6],
                            lp_q[5], lpn_q[5], lp_q[4], lpn_q[4]}; // R14
  assign parity_byte_hi  = {cp_q, lp_q[8], lpn_q[8]}; // R14
endmodule // nbec_ecc

// [design/nbec_top.v]
// nbec_top.v: nand flash controller, boot copy and ecc
// assumes: flash pins synchronous to clk; oe steers the d bus
`timescale 1ns/10ps
`include "nbec_consts.vh"
//
// Contract
// R01: boot copies first 4 KB into sram
// R02: map sram at zero, then release cpu
// R03: cpu starts from sram after boot
// R04: no ecc during boot; flash must be clean
// R05: auto boot only in little endian
// R06: mode straps 00 enable auto boot
// R07: page strap: 0=256, 1=512 bytes
// R08: address strap: 0=three, 1=four cycles
// R09: host: config, command, address, then data
// R10: host checks ready before read, after program
// R11: drive latches, strobes, select; sample ready
// R12: three parity bytes per 512 bytes
// R13: 18 line bits plus 6 column bits
// R14: fixed packing of the three parity bytes
// R15: parity over written data
// R16: parity over read data, compared
// R17: detect only, software corrects
// R18: address zero decode follows boot mode
// R19: sram usable as memory after boot
// R20: enable bit clears after auto boot
// R21: phases last clock times field plus one
// R22: boot waits for ready before each page
module nbec_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire [1:0]  boot_mode_straps,
  input  wire        page_size_strap,
  input  wire        addr_cycle_strap,
  input  wire        little_endian,
  input  wire        cfg_wr,
  input  wire        cfg_en,
  input  wire        cfg_ecc_init,
  input  wire        cfg_ce_off,
  input  wire [2:0]  cfg_latch_setup_time,
  input  wire [2:0]  cfg_strobe_active_time,
  input  wire [2:0]  cfg_strobe_hold_time,
  input  wire        cmd_wr,
  input  wire [7:0]  cmd_byte,
  input  wire        adr_wr,
  input  wire [7:0]  adr_byte,
  input  wire        dat_wr,
  input  wire [7:0]  dat_wbyte,
  input  wire        dat_rd,
  input  wire        ecc_check,
  input  wire [23:0] ecc_ref,
  input  wire        remap_req,
  input  wire        sram_req,
  input  wire        sram_we,
  input  wire [11:0] sram_addr,
  input  wire [7:0]  sram_wdata,
  output wire [7:0]  sram_rdata,
  input  wire [7:0]  flash_d_in,
  input  wire        flash_ready_busy_in,
  output reg  [7:0]  flash_d_out_q,
  output reg         flash_d_oe_q,
  output reg         flash_cle_q,
  output reg         flash_ale_q,
  output reg         flash_chip_sel_q,
  output reg         flash_read_strobe_n_q,
  output reg         flash_write_strobe_n_q,
  output reg         cpu_reset_n_q,
  output reg  [1:0]  map_zero_sel_q,
  output reg         sram_hi_vis_q,
  output reg         boot_done_q,
  output reg         cfg_en_q,
  output reg         page_size_q,
  output reg         addr_cycle_q,
  output reg         busy_q,
  output reg         ready_busy_indication_q,
  output reg  [7:0]  rd_data_q,
  output reg         rd_valid_q,
  output reg         ecc_mismatch_q,
  output wire [7:0]  parity_byte_lo,
  output wire [7:0]  parity_byte_mid,
  output wire [7:0]  parity_byte_hi
);
  // engine phases
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_SET  = 2'h1;
  localparam [1:0] PH_ACT  = 2'h2;
  localparam [1:0] PH_HOLD = 2'h3;
  // boot sequencer states
  localparam [2:0] B_STRAP = 3'h0;
  localparam [2:0] B_WRB   = 3'h1;
  localparam [2:0] B_CMD   = 3'h2;
  localparam [2:0] B_ADR   = 3'h3;
  localparam [2:0] B_TWB   = 3'h4;
  localparam [2:0] B_WRD   = 3'h5;
  localparam [2:0] B_RD    = 3'h6;
  localparam [2:0] B_RUN   = 3'h7;
  localparam [3:0] TWB_CYC = `NBEC_TWB_CYC;

  reg        rst_s1_q;       // reset sync stage 1
  reg        rst_n_q;        // internal reset
  reg [2:0]  bst_q;          // boot state
  reg [12:0] bcnt_q;         // bytes copied so far
  reg [1:0]  aidx_q;         // address byte index
  reg [3:0]  wcnt_q;         // busy-settle counter
  reg        ce_off_q;       // software chip select off
  reg [2:0]  tset_q;         // latch setup field
  reg [2:0]  tact_q;         // strobe active field
  reg [2:0]  thold_q;        // strobe hold field
  reg        ecc_init_q;     // one-cycle ecc restart
  reg [1:0]  ph_q;           // engine phase
  reg [2:0]  pcnt_q;         // engine phase counter
  reg [1:0]  op_q;           // engine operation
  reg        done_q;         // engine finished, one cycle
  reg [7:0]  eng_rd_q;       // byte read by the engine
  reg        sw_op_q;        // current op came from software
  reg [1:0]  ph_d;
  reg [2:0]  pcnt_d;
  reg        start;          // engine start this cycle
  reg [1:0]  st_op;          // op to start
  reg [7:0]  st_byte;        // byte to send
  reg [7:0]  boot_adr;       // boot address byte for aidx_q
  wire       sw_start;       // software asks for an op
  wire       boot_ok;        // straps select auto boot
  wire [3:0] page;           // page number being copied
  wire [12:0] bcnt_n;        // next copy count
  wire       pg_end;         // next byte opens a new page
  wire [1:0] adr_last;       // last address byte index
  wire       sram_we_i;
  wire [11:0] sram_addr_i;
  wire [7:0] sram_wdata_i;
  wire       ecc_valid;

  // two-flop reset release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // auto boot: nand straps, little endian
  assign boot_ok = (boot_mode_straps == `NBEC_OM_NAND) // R06
                   && little_endian; // R05
  assign page = page_size_q ? bcnt_q[12:`NBEC_PG_LOG512] // R07
                            : bcnt_q[11:`NBEC_PG_LOG256];
  assign bcnt_n = bcnt_q + 13'h0001;
  assign pg_end = page_size_q ? (bcnt_n[`NBEC_PG_LOG512-1:0] == 9'h000)
                              : (bcnt_n[`NBEC_PG_LOG256-1:0] == 8'h00);
  assign adr_last = addr_cycle_q ? `NBEC_ADR_LAST4 // R08
                                 : `NBEC_ADR_LAST3;
  assign sw_start = (bst_q == B_RUN) && cfg_en_q && (ph_q == PH_IDLE)
                    && (cmd_wr || adr_wr || dat_wr || dat_rd);

  // boot address: column 0, page, then zeros
  always @* begin
    case (aidx_q)
      2'h1:    boot_adr = {4'h0, page};
      default: boot_adr = 8'h00;
    endcase
  end

  // engine start: software in run, else boot
  always @* begin
    start   = 1'b0;
    st_op   = `NBEC_OP_CMD;
    st_byte = 8'h00;
    if (sw_start) begin
      start = 1'b1;
      if (cmd_wr) begin
        st_byte = cmd_byte;
      end else if (adr_wr) begin
        st_op   = `NBEC_OP_ADR;
        st_byte = adr_byte;
      end else if (dat_wr) begin
        st_op   = `NBEC_OP_WR;
        st_byte = dat_wbyte;
      end else begin
        st_op   = `NBEC_OP_RD;
      end
    end else if (ph_q == PH_IDLE && !done_q) begin
      case (bst_q)
        B_WRB: begin
          start   = ready_busy_indication_q; // R22
          st_byte = `NBEC_CMD_READ;
        end
        B_CMD, B_ADR: begin
          start   = (bst_q == B_ADR);
          st_op   = `NBEC_OP_ADR;
          st_byte = boot_adr;
        end
        B_WRD: begin
          start = ready_busy_indication_q; // R22
          st_op = `NBEC_OP_RD;
        end
        default: start = 1'b0;
      endcase
    end
  end

  // boot: copy page by page, then release cpu
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bst_q          <= B_STRAP;
      bcnt_q         <= 13'h0000;
      aidx_q         <= 2'h0;
      wcnt_q         <= 4'h0;
      cpu_reset_n_q  <= 1'b0;
      boot_done_q    <= 1'b0;
      map_zero_sel_q <= `NBEC_MAP_ROM;
      sram_hi_vis_q  <= 1'b0;
      page_size_q    <= 1'b0;
      addr_cycle_q   <= 1'b0;
    end else if (ce) begin
      case (bst_q)
        B_STRAP: begin
          // straps taken once after release
          page_size_q  <= page_size_strap; // R07
          addr_cycle_q <= addr_cycle_strap; // R08
          if (boot_ok) begin
            bst_q          <= B_WRB; // R01
            map_zero_sel_q <= `NBEC_MAP_SRAM;
          end else begin
            bst_q          <= B_RUN;
            cpu_reset_n_q  <= 1'b1;
            sram_hi_vis_q  <= 1'b1; // R18
          end
        end
        B_WRB: begin
          aidx_q <= 2'h0;
          if (start) begin
            bst_q <= B_CMD;
          end
        end
        B_CMD: begin
          if (done_q) begin
            bst_q <= B_ADR;
          end
        end
        B_ADR: begin
          if (done_q) begin
            if (aidx_q == adr_last) begin
              bst_q  <= B_TWB;
              wcnt_q <= 4'h0;
            end else begin
              aidx_q <= aidx_q + 2'h1;
            end
          end
        end
        B_TWB: begin
          // let ready drop before trusting it
          wcnt_q <= wcnt_q + 4'h1;
          if (wcnt_q == TWB_CYC) begin
            bst_q <= B_WRD;
          end
        end
        B_WRD: begin
          if (start) begin
            bst_q <= B_RD;
          end
        end
        B_RD: begin
          if (done_q) begin
            bcnt_q <= bcnt_n;
            if (bcnt_n == `NBEC_BOOT_BYTES) begin
              // map already set; cpu leaves reset
              bst_q         <= B_RUN;
              boot_done_q   <= 1'b1;
              cpu_reset_n_q <= 1'b1; // R02 R03
            end else if (pg_end) begin
              bst_q <= B_WRB;
            end else begin
              bst_q <= B_WRD;
            end
          end
        end
        B_RUN: begin
          // software moves sdram to zero
          if (remap_req && map_zero_sel_q == `NBEC_MAP_SRAM) begin
            map_zero_sel_q <= `NBEC_MAP_SDRAM; // R18
            sram_hi_vis_q  <= 1'b1; // R19
          end
        end
        default: bst_q <= B_STRAP;
      endcase
    end
  end

  // config; boot end clears enable, select
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_en_q   <= 1'b0;
      ce_off_q   <= 1'b1;
      tset_q     <= `NBEC_LATCH_SETUP_TIME_RST;
      tact_q     <= `NBEC_TWRPH_RST;
      thold_q    <= `NBEC_TWRPH_RST;
      ecc_init_q <= 1'b0;
    end else if (ce) begin
      ecc_init_q <= 1'b0;
      if (bst_q == B_RD && done_q && bcnt_n == `NBEC_BOOT_BYTES) begin
        cfg_en_q <= 1'b0; // R20
        ce_off_q <= 1'b1;
      end else if (cfg_wr && bst_q == B_RUN) begin
        cfg_en_q   <= cfg_en;
        ce_off_q   <= cfg_ce_off;
        tset_q     <= cfg_latch_setup_time;
        tact_q     <= cfg_strobe_active_time;
        thold_q    <= cfg_strobe_hold_time;
        ecc_init_q <= cfg_ecc_init;
      end
    end
  end

  // next phase: field plus one cycles each
  always @* begin
    ph_d   = ph_q;
    pcnt_d = pcnt_q;
    case (ph_q)
      PH_IDLE: begin
        if (start) begin
          ph_d   = PH_SET;
          pcnt_d = tset_q; // R21
        end
      end
      PH_SET: begin
        if (pcnt_q == 3'h0) begin
          ph_d   = PH_ACT;
          pcnt_d = tact_q; // R21
        end else begin
          pcnt_d = pcnt_q - 3'h1;
        end
      end
      PH_ACT: begin
        if (pcnt_q == 3'h0) begin
          ph_d   = PH_HOLD;
          pcnt_d = thold_q; // R21
        end else begin
          pcnt_d = pcnt_q - 3'h1;
        end
      end
      PH_HOLD: begin
        if (pcnt_q == 3'h0) begin
          ph_d = PH_IDLE;
        end else begin
          pcnt_d = pcnt_q - 3'h1;
        end
      end
      default: ph_d = PH_IDLE;
    endcase
  end

  // engine state and flash pins, registered
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ph_q                   <= PH_IDLE;
      pcnt_q                 <= 3'h0;
      op_q                   <= `NBEC_OP_CMD;
      done_q                 <= 1'b0;
      eng_rd_q               <= 8'h00;
      sw_op_q                <= 1'b0;
      flash_d_out_q          <= 8'h00;
      flash_d_oe_q           <= 1'b0;
      flash_cle_q            <= 1'b0;
      flash_ale_q            <= 1'b0;
      flash_chip_sel_q       <= 1'b0;
      flash_read_strobe_n_q  <= 1'b1;
      flash_write_strobe_n_q <= 1'b1;
      busy_q                 <= 1'b0;
      ready_busy_indication_q <= 1'b0;
    end else if (ce) begin
      ph_q   <= ph_d;
      pcnt_q <= pcnt_d;
      done_q <= (ph_q == PH_HOLD) && (ph_d == PH_IDLE);
      busy_q <= (ph_d != PH_IDLE);
      ready_busy_indication_q <= flash_ready_busy_in; // R11
      if (start) begin
        op_q          <= st_op;
        sw_op_q       <= sw_start;
        flash_d_out_q <= st_byte;
      end
      if (ph_q == PH_ACT && ph_d == PH_HOLD && op_q == `NBEC_OP_RD) begin
        eng_rd_q <= flash_d_in; // R11
      end
      // select held through boot, else software's
      flash_chip_sel_q <= (bst_q != B_RUN && bst_q != B_STRAP)
                          || (cfg_en_q && !ce_off_q); // R11
      if (ph_d == PH_IDLE) begin
        flash_cle_q  <= 1'b0;
        flash_ale_q  <= 1'b0;
        flash_d_oe_q <= 1'b0;
      end else if (start) begin
        flash_cle_q  <= (st_op == `NBEC_OP_CMD); // R11
        flash_ale_q  <= (st_op == `NBEC_OP_ADR); // R11
        flash_d_oe_q <= (st_op != `NBEC_OP_RD);
      end
      flash_write_strobe_n_q <= !(ph_d == PH_ACT
                                  && op_q != `NBEC_OP_RD); // R11
      flash_read_strobe_n_q  <= !(ph_d == PH_ACT
                                  && op_q == `NBEC_OP_RD); // R11
    end
  end

  // read data and ecc compare
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data_q      <= 8'h00;
      rd_valid_q     <= 1'b0;
      ecc_mismatch_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= done_q && sw_op_q && op_q == `NBEC_OP_RD;
      if (done_q && sw_op_q && op_q == `NBEC_OP_RD) begin
        rd_data_q <= eng_rd_q;
      end
      // flag only; software fixes bits
      if (ecc_check) begin
        ecc_mismatch_q <= ({parity_byte_hi, parity_byte_mid,
                            parity_byte_lo} != ecc_ref); // R16 R17
      end
    end
  end

  // ecc sees software data only
  assign ecc_valid = sw_op_q && (ph_q == PH_HOLD) && (ph_d == PH_IDLE)
                     && (op_q == `NBEC_OP_WR || op_q == `NBEC_OP_RD); // R04

  nbec_ecc u_ecc (
    .clk             (clk),
    .rst_n           (rst_n_q),
    .ce              (ce),
    .init            (ecc_init_q),
    .valid           (ecc_valid), // R15 R16
    .data            (op_q == `NBEC_OP_RD ? eng_rd_q : flash_d_out_q),
    .parity_byte_lo  (parity_byte_lo),
    .parity_byte_mid (parity_byte_mid),
    .parity_byte_hi  (parity_byte_hi)
  );

  // boot copier owns the buffer during reset
  assign sram_we_i    = cpu_reset_n_q ? (sram_req && sram_we) // R19
                                      : (bst_q == B_RD && done_q); // R01
  assign sram_addr_i  = cpu_reset_n_q ? sram_addr : bcnt_q[11:0];
  assign sram_wdata_i = cpu_reset_n_q ? sram_wdata : eng_rd_q;

  nbec_sram u_sram (
    .clk     (clk),
    .ce      (ce),
    .we      (sram_we_i),
    .addr    (sram_addr_i),
    .wdata   (sram_wdata_i),
    .rdata_q (sram_rdata)
  );
endmodule // nbec_top

// [bench/nbec_props.sv]
// nbec_props.sv: pin assertions for nbec_top
// assumes: bench keeps timing fields steady once loaded
`timescale 1ns/10ps
module nbec_props (
  input wire        clk, nrst, cmd_wr, dat_wr, dat_rd, ecc_check,
  input wire        flash_d_oe_q, flash_cle_q, flash_ale_q, busy_q,
  input wire        flash_read_strobe_n_q, flash_write_strobe_n_q,
  input wire        cpu_reset_n_q, sram_hi_vis_q, boot_done_q, cfg_en_q,
  input wire        rd_valid_q, ecc_mismatch_q,
  input wire [1:0]  map_zero_sel_q,
  input wire [2:0]  cfg_strobe_active_time,
  input wire [7:0]  cmd_byte, flash_d_out_q,
  input wire [7:0]  parity_byte_lo, parity_byte_mid, parity_byte_hi,
  input wire [23:0] ecc_ref
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [3:0] low_q;  // cycles the write strobe has stood low
  always @(posedge clk or negedge nrst)
    if (!nrst) low_q <= 4'h0;
    else low_q <= flash_write_strobe_n_q ? 4'h0 : low_q + 4'h1;
  // software read ends, busy drops, data flagged
  sequence s_rd_end;
    $rose(flash_read_strobe_n_q) && boot_done_q && cfg_en_q;
  endsequence
  sequence s_rd_out;
    !busy_q ##1 rd_valid_q;
  endsequence
  property p_strobe_excl;
    flash_read_strobe_n_q || flash_write_strobe_n_q; endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("both strobes low");
  property p_cmd_latch; $rose(busy_q) && $past(cmd_wr) |-> flash_cle_q &&
    !flash_ale_q && flash_d_oe_q && flash_d_out_q == $past(cmd_byte);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch)
    else $error("cmd not latched");
  property p_refuse;
    !cfg_en_q && !busy_q && (dat_wr || dat_rd) |=> !busy_q; endproperty
  a_refuse: assert property (p_refuse)
    else $error("taken while disabled");
  property p_we_len; $rose(flash_write_strobe_n_q) |->
    low_q == (boot_done_q ? cfg_strobe_active_time : 3'h0) + 4'h1;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("strobe length wrong");
  property p_rd_done; s_rd_end |-> ##[1:8] s_rd_out; endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read not flagged");
  property p_boot_rel; $rose(cpu_reset_n_q) && boot_done_q |->
    !cfg_en_q && map_zero_sel_q == 2'h1; endproperty
  a_boot_rel: assert property (p_boot_rel)
    else $error("boot release wrong");
  property p_nonboot; $rose(cpu_reset_n_q) && !boot_done_q |->
    map_zero_sel_q == 2'h0 && sram_hi_vis_q; endproperty
  a_nonboot: assert property (p_nonboot)
    else $error("non boot map wrong");
  property p_ecc_cmp; ecc_check |=> ecc_mismatch_q == ($past({parity_byte_hi,
    parity_byte_mid, parity_byte_lo}) != $past(ecc_ref)); endproperty
  a_ecc_cmp: assert property (p_ecc_cmp)
    else $error("ecc compare wrong");
endmodule // nbec_props
bind nbec_top nbec_props u_nbec_props (.*);

// [bench/nbec_flash_model.sv]
// nbec_flash_model.sv: nand flash on the controller pins
// assumes: rdy high means ready
`timescale 1ns/10ps
module nbec_flash_model (
  input  wire       clk, cle, ale, re_n, we_n,
  output reg  [7:0] dq,
  output reg        rdy,
  output integer    n_cmd, n_adr
);
  reg [15:0] cnt = 16'h0000;  // bytes read, sets data
  reg        act = 1'b0;      // a read strobe is open
  initial {dq, rdy, n_cmd, n_adr} = {8'h00, 1'b1, 64'h0};
  // count latched bytes as the strobe closes
  always @(posedge we_n) begin
    if (cle) n_cmd = n_cmd + 1;
    if (ale) n_adr = n_adr + 1;
  end
  // busy after each address byte
  always @(negedge ale) begin
    rdy = 1'b0;
    repeat (4) @(posedge clk);
    rdy = 1'b1;
  end
  // clean pattern while read, inverse once released
  always @(negedge re_n) begin
    act = 1'b1;
    dq = cnt[7:0] ^ cnt[15:8];
  end
  always @(posedge re_n) if (act) begin
    #5 cnt = cnt + 16'h0001;
    act = 1'b0;
    dq = ~dq;
  end
endmodule // nbec_flash_model

// [bench/nbec_test.sv]
// nbec_test.sv: self-checking bench for nbec_top
// assumes: flash model on the pins, checker bound from its own file
`timescale 1ns/10ps
module nbec_test;
  reg        clk, nrst, ce, page_size_strap, addr_cycle_strap, little_endian;
  reg        cfg_wr, cfg_en, cfg_ecc_init, cfg_ce_off, cmd_wr, adr_wr;
  reg        dat_wr, dat_rd, ecc_check, remap_req, sram_req, sram_we, seen;
  reg [1:0]  boot_mode_straps;
  reg [2:0]  cfg_latch_setup_time, cfg_strobe_active_time;
  reg [2:0]  cfg_strobe_hold_time;
  reg [7:0]  cmd_byte, adr_byte, dat_wbyte, sram_wdata;
  reg [11:0] sram_addr;
  reg [23:0] ecc_ref;
  wire [7:0] sram_rdata, flash_d_in, flash_d_out_q, rd_data_q;
  wire [7:0] parity_byte_lo, parity_byte_mid, parity_byte_hi;
  wire [1:0] map_zero_sel_q;
  wire       flash_ready_busy_in, flash_d_oe_q, flash_cle_q, flash_ale_q;
  wire       flash_chip_sel_q, flash_read_strobe_n_q, flash_write_strobe_n_q;
  wire       cpu_reset_n_q, sram_hi_vis_q, boot_done_q, cfg_en_q, busy_q;
  wire       page_size_q, addr_cycle_q, ready_busy_indication_q;
  wire       rd_valid_q, ecc_mismatch_q;
  integer    n_mismatch = 0, checks_done = 0, cyc = 0, n_cmd, n_adr, k, j;
  nbec_top u_nbec_top (.*);
  nbec_flash_model u_nbec_flash_model (.clk(clk), .cle(flash_cle_q),
    .ale(flash_ale_q), .re_n(flash_read_strobe_n_q),
    .we_n(flash_write_strobe_n_q), .dq(flash_d_in),
    .rdy(flash_ready_busy_in), .n_cmd(n_cmd), .n_adr(n_adr));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ceiling above the boot copy's length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      n_mismatch = n_mismatch + 1;
      results;
    end
  end
  task tick; begin @(posedge clk); #2; end endtask
  function [7:0] pat(input [15:0] n); pat = n[7:0] ^ n[15:8]; endfunction
  task cmp(input string nm, input [23:0] e, input [23:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one software cycle: 0 cmd, 1 addr, 2 write, 3 read; wait out busy
  task op(input [1:0] kind, input [7:0] b);
    integer i;
    begin
      {cmd_byte, adr_byte, dat_wbyte} = {3{b}};
      {cmd_wr, adr_wr, dat_wr, dat_rd} = 4'h8 >> kind;
      tick;
      {cmd_wr, adr_wr, dat_wr, dat_rd} = 4'h0;
      tick;
      seen = busy_q;
      for (i = 0; i < 40 && busy_q !== 1'b0; i = i + 1) tick;
    end
  endtask
  task cfg(input en, input init);
    begin
      {cfg_en, cfg_ecc_init, cfg_wr} = {en, init, 1'b1};
      tick;
      cfg_wr = 1'b0;
      tick;
    end
  endtask
  task sram(input we, input [11:0] a, input [7:0] d);
    begin
      {sram_req, sram_we, sram_addr, sram_wdata} = {1'b1, we, a, d};
      tick;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    {nrst, cfg_wr, cfg_en, cfg_ecc_init, cfg_ce_off, cmd_wr} = 6'h00;
    {adr_wr, dat_wr, dat_rd, ecc_check, remap_req, sram_req} = 6'h00;
    {sram_we, cmd_byte, adr_byte, dat_wbyte, sram_wdata} = 33'h0;
    {ce, page_size_strap, addr_cycle_strap, little_endian} = 4'hF;
    {boot_mode_straps, ecc_ref, sram_addr} = 38'h0;
    {cfg_latch_setup_time, cfg_strobe_active_time,
     cfg_strobe_hold_time} = 9'h051;
    repeat (20) tick;
    nrst = 1'b1;
    wait (cpu_reset_n_q === 1'b1);
    tick;
    cmp("map", 24'h1, map_zero_sel_q);
    cmp("cfg_en", 24'h0, cfg_en_q);
    cmp("sel", 24'h0, flash_chip_sel_q);
    cmp("pages", 24'h8, n_cmd[23:0]);
    cmp("adr_bytes", 24'h20, n_adr[23:0]);
    cmp("page_q", 24'h1, page_size_q);
    cmp("adr_q", 24'h1, addr_cycle_q);
    for (k = 0; k < 4096; k = k + 1) begin
      sram(1'b0, k[11:0], 8'h00);
      cmp("image", pat(k[15:0]), sram_rdata);
    end
    sram(1'b1, 12'hFFF, 8'h5A);
    sram(1'b0, 12'hFFF, 8'h00);
    sram_req = 1'b0;
    cmp("reuse", 24'h5A, sram_rdata);
    $display("boot copy test done");
    remap_req = 1'b1;
    tick;
    remap_req = 1'b0;
    tick;
    cmp("remap", 24'h2, map_zero_sel_q);
    op(2'h2, 8'h00);
    cmp("taken", 24'h0, seen);
    $display("remap test done");
    cfg(1'b1, 1'b1);
    cfg(1'b1, 1'b0);
    cmp("sel", 24'h1, flash_chip_sel_q);
    op(2'h0, 8'h80);
    cmp("taken", 24'h1, seen);
    op(2'h1, 8'h00);
    for (k = 0; k < 512; k = k + 1)
      op(2'h2, (k == 9'h1A5) ? 8'h20 : 8'h00);
    cmp("parity", 24'h9A9966,
      {parity_byte_hi, parity_byte_mid, parity_byte_lo});
    for (j = 0; j < 2; j = j + 1) begin
      {ecc_check, ecc_ref} = {1'b1, 24'h9A9966 ^ j[23:0]};
      tick;
      ecc_check = 1'b0;
      tick;
      cmp("ecc_miss", j[23:0], ecc_mismatch_q);
    end
    cmp("ready", 24'h1, ready_busy_indication_q);
    op(2'h3, 8'h00);
    tick;
    cmp("rd_data", pat(16'h1000), rd_data_q);
    $display("software test done");
    for (j = 0; j < 2; j = j + 1) begin
      nrst = 1'b0;
      boot_mode_straps = j ? 2'h0 : 2'h2;
      little_endian = !j;
      tick;
      nrst = 1'b1;
      repeat (8) tick;
      cmp("cpu_rst", 24'h1, cpu_reset_n_q);
      cmp("booted", 24'h0, boot_done_q);
      cmp("cmds", 24'h9, n_cmd[23:0]);
      cmp("map", 24'h0, map_zero_sel_q);
    end
    $display("non boot test done");
    results;
  end
endmodule // nbec_test
